// ### rtl/tlic_pkg.sv
package tlic_pkg;
  localparam int          NUM_SRC      = 9;
  localparam int          IDX_W        = 4;
  localparam logic [7:0]  ADDR_MAIN    = 8'hA8;
  localparam logic [7:0]  ADDR_AUX     = 8'hA9;
  localparam logic [7:0]  ADDR_LEVEL   = 8'hB8;
  localparam logic [7:0]  RST_MAIN     = 8'h00;
  localparam logic [7:0]  RST_AUX      = 8'h00;
  localparam logic [7:0]  RST_LEVEL    = 8'h00;
  localparam logic [7:0]  AUX_USED     = 8'h03;
  localparam logic [7:0]  ZERO_BYTE    = 8'h00;
  // Bit-address group: upper five bits of a bit address name the register
  localparam logic [4:0]  BGRP_MAIN    = 5'h15;
  localparam logic [4:0]  BGRP_LEVEL   = 5'h17;
  // Main gate register fields
  localparam int          GLOBAL_GATE  = 7;
  localparam int          CONV_INT_ON  = 6;
  localparam int          TMR2_INT_ON  = 5;
  localparam int          UART_INT_ON  = 4;
  localparam int          TMR1_INT_ON  = 3;
  localparam int          XINT1_ON     = 2;
  localparam int          TMR0_INT_ON  = 1;
  localparam int          XINT0_ON     = 0;
  // Level register fields
  localparam int          TWOWIRE_SPI_HIGH = 7;
  localparam int          CONV_HIGH    = 6;
  localparam int          TMR2_HIGH    = 5;
  localparam int          UART_HIGH    = 4;
  localparam int          TMR1_HIGH    = 3;
  localparam int          XINT1_HIGH   = 2;
  localparam int          TMR0_HIGH    = 1;
  localparam int          XINT0_HIGH   = 0;
  // Aux gate register fields
  localparam int          SUPPLY_MON_INT_ON  = 1;
  localparam int          TWOWIRE_SPI_INT_ON = 0;
  // Source index equals polling rank, 0 highest
  localparam int          SRC_SUPPLY   = 0;
  localparam int          SRC_XINT0    = 1;
  localparam int          SRC_CONV     = 2;
  localparam int          SRC_TMR0     = 3;
  localparam int          SRC_XINT1    = 4;
  localparam int          SRC_TMR1     = 5;
  localparam int          SRC_TWOWIRE  = 6;
  localparam int          SRC_UART     = 7;
  localparam int          SRC_TMR2     = 8;
  localparam logic [15:0] VEC_TABLE [NUM_SRC] = '{
    16'h0043, 16'h0003, 16'h0033, 16'h000B, 16'h0013,
    16'h001B, 16'h003B, 16'h0023, 16'h002B
  };
endpackage : tlic_pkg

// ### rtl/tlic_arb_if.sv
`timescale 1ns/1ps
interface tlic_arb_if;
  import tlic_pkg::*;
  logic [NUM_SRC-1:0] eligible;
  logic [NUM_SRC-1:0] highMask;
  logic               inSvcHigh;
  logic               inSvcLow;
  logic               winValid;
  logic [IDX_W-1:0]   winIdx;
  logic               winHigh;
  modport ctrl (output eligible, output highMask, output inSvcHigh, output inSvcLow,
                input winValid, input winIdx, input winHigh);
  modport arb  (input eligible, input highMask, input inSvcHigh, input inSvcLow,
                output winValid, output winIdx, output winHigh);
endinterface : tlic_arb_if

// ### rtl/tlic_arbiter.sv
`timescale 1ns/1ps
module tlic_arbiter #(
  parameter int NUM_SRC = tlic_pkg::NUM_SRC,
  parameter int IDX_W   = tlic_pkg::IDX_W
) (
  tlic_arb_if.arb arb
);
  import tlic_pkg::*;

  if (NUM_SRC > (1 << IDX_W) || NUM_SRC < 1 || NUM_SRC != tlic_pkg::NUM_SRC
      || IDX_W != tlic_pkg::IDX_W) begin : g_chk
    $error("tlic_arbiter: source count or index width does not fit the carrier");
  end

  // Lowest set index wins: index order is the polling order
  function automatic logic [IDX_W-1:0] firstSet(input logic [NUM_SRC-1:0] v);
    logic [IDX_W-1:0] r;
    r = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = IDX_W'(i);
      end
    end
    return r;
  endfunction : firstSet

  wire [NUM_SRC-1:0] highCand = arb.eligible & arb.highMask;
  wire [NUM_SRC-1:0] lowCand  = arb.eligible & ~arb.highMask;
  // High in service blocks all; low in service admits only high
  wire               takeHigh = !arb.inSvcHigh && (|highCand);   // RL10
  wire               takeLow  = !arb.inSvcHigh && !arb.inSvcLow && !(|highCand)
                                && (|lowCand);                   // RL10

  assign arb.winValid = takeHigh || takeLow;
  assign arb.winHigh  = takeHigh;
  assign arb.winIdx   = takeHigh ? firstSet(highCand) : firstSet(lowCand); // RL11
endmodule : tlic_arbiter

// ### rtl/tlic_ctrl.sv
`timescale 1ns/1ps
// Contract
// RL1 - Nine sources, each on one of two levels
// RL2 - Global gate bit 7 blocks all sources
// RL3 - Main bits 6..0 enable the seven sources
// RL4 - Main register resets zero, byte and bit access
// RL5 - Level bits pick high or low per source
// RL6 - Level register resets zero, byte and bit access
// RL7 - Aux register resets zero, byte writes only
// RL8 - Aux bits 1,0 enable monitor and serial
// RL9 - Aux bits 7..2 reserved, no function
// RL10 - High preempts low; same level never preempts
// RL11 - Same-level ties settle by fixed polling order
// RL12 - Accepted source hands its vector to core
// RL13 - Request needs pending, own enable, global gate
module tlic_ctrl (
  input  wire logic                           ref_clk,
  input  wire logic                           rst_b,
  input  wire logic [7:0]                     sfrAddr,
  input  wire logic                           sfrWrEn,
  input  wire logic [7:0]                     sfrWrData,
  input  wire logic                           sfrRdEn,
  output logic      [7:0]                     sfrRdData,
  input  wire logic [7:0]                     bitAddr,
  input  wire logic                           bitWrEn,
  input  wire logic                           bitWrVal,
  input  wire logic [tlic_pkg::NUM_SRC-1:0]   pendIn,
  input  wire logic                           irqAck,
  input  wire logic                           irqDone,
  output logic                                irqReq,
  output logic      [15:0]                    irqVector,
  output logic                                irqHigh,
  output logic      [1:0]                     inService
);
  import tlic_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]         mainGate_r;
  logic [7:0]         auxGate_r;
  logic [7:0]         level_r;
  logic [7:0]         rdData_r;
  logic               inSvcHigh_r;
  logic               inSvcLow_r;
  logic               irqReq_r;
  logic [15:0]        irqVector_r;
  logic               irqHigh_r;
  logic [IDX_W-1:0]   irqSrc_r;
  logic [NUM_SRC-1:0] eligDly_r;
  logic [NUM_SRC-1:0] highDly_r;

  //////////////////////////////////////////////////////////////////////////////
  // Access decode
  wire              wrMain    = sfrWrEn && (sfrAddr == ADDR_MAIN);
  wire              wrAux     = sfrWrEn && (sfrAddr == ADDR_AUX);
  wire              wrLevel   = sfrWrEn && (sfrAddr == ADDR_LEVEL);
  wire              bitMain   = bitWrEn && (bitAddr[7:3] == BGRP_MAIN);
  wire              bitLevel  = bitWrEn && (bitAddr[7:3] == BGRP_LEVEL);

  // Set or clear one bit of a bit-addressable register
  function automatic logic [7:0] applyBit(input logic [7:0] cur,
                                          input logic [2:0] pos,
                                          input logic       val);
    logic [7:0] msk;
    msk = 8'h01 << pos;
    return val ? (cur | msk) : (cur & ~msk);
  endfunction : applyBit

  // Byte write takes priority over a bit write in the same cycle
  wire [7:0] mainGate_nxt = wrMain ? sfrWrData :
                            bitMain ? applyBit(mainGate_r, bitAddr[2:0], bitWrVal)
                                    : mainGate_r;                         // RL4
  wire [7:0] level_nxt    = wrLevel ? sfrWrData :
                            bitLevel ? applyBit(level_r, bitAddr[2:0], bitWrVal)
                                     : level_r;                           // RL6
  wire [7:0] auxGate_nxt  = wrAux ? (sfrWrData & AUX_USED) : auxGate_r;   // RL7 RL9

  wire [7:0] rdData_nxt   = !sfrRdEn ? rdData_r :
                            (sfrAddr == ADDR_MAIN)  ? mainGate_r :
                            (sfrAddr == ADDR_AUX)   ? auxGate_r :
                            (sfrAddr == ADDR_LEVEL) ? level_r : ZERO_BYTE;

  //////////////////////////////////////////////////////////////////////////////
  // Source mapping in polling order
  wire [NUM_SRC-1:0] enVec = {
    mainGate_r[TMR2_INT_ON], mainGate_r[UART_INT_ON], auxGate_r[TWOWIRE_SPI_INT_ON],
    mainGate_r[TMR1_INT_ON], mainGate_r[XINT1_ON], mainGate_r[TMR0_INT_ON],
    mainGate_r[CONV_INT_ON], mainGate_r[XINT0_ON], auxGate_r[SUPPLY_MON_INT_ON]
  };                                                                      // RL1 RL3 RL8
  // The supply monitor has no level bit and is always low level
  wire [NUM_SRC-1:0] highVec = {
    level_r[TMR2_HIGH], level_r[UART_HIGH], level_r[TWOWIRE_SPI_HIGH],
    level_r[TMR1_HIGH], level_r[XINT1_HIGH], level_r[TMR0_HIGH],
    level_r[CONV_HIGH], level_r[XINT0_HIGH], 1'b0
  };                                                                      // RL5
  wire [NUM_SRC-1:0] eligVec = pendIn & enVec & {NUM_SRC{mainGate_r[GLOBAL_GATE]}}; // RL2 RL13

  tlic_arb_if arbBus ();
  assign arbBus.eligible  = eligVec;
  assign arbBus.highMask  = highVec;
  assign arbBus.inSvcHigh = inSvcHigh_r;
  assign arbBus.inSvcLow  = inSvcLow_r;

  tlic_arbiter #(
    .NUM_SRC (NUM_SRC),
    .IDX_W   (IDX_W)
  ) u_arb (
    .arb (arbBus.arb)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Service tracking: acceptance sets the level, completion clears the top one
  wire ackHigh = irqAck && irqReq_r && irqHigh_r;
  wire ackLow  = irqAck && irqReq_r && !irqHigh_r;
  wire inSvcHigh_nxt = ackHigh || (inSvcHigh_r && !irqDone);
  wire inSvcLow_nxt  = ackLow || (inSvcLow_r && !(irqDone && !inSvcHigh_r));
  // Drop the request on the ack cycle so a stale vector is never re-offered
  wire irqReq_nxt    = arbBus.winValid && !irqAck;                        // RL10 RL13

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      mainGate_r  <= RST_MAIN;
      auxGate_r   <= RST_AUX;
      level_r     <= RST_LEVEL;
      rdData_r    <= ZERO_BYTE;
      inSvcHigh_r <= 1'b0;
      inSvcLow_r  <= 1'b0;
      irqReq_r    <= 1'b0;
      irqVector_r <= VEC_TABLE[SRC_SUPPLY];
      irqHigh_r   <= 1'b0;
      irqSrc_r    <= '0;
      eligDly_r   <= '0;
      highDly_r   <= '0;
    end else begin
      mainGate_r  <= mainGate_nxt;
      auxGate_r   <= auxGate_nxt;
      level_r     <= level_nxt;
      rdData_r    <= rdData_nxt;
      inSvcHigh_r <= inSvcHigh_nxt;
      inSvcLow_r  <= inSvcLow_nxt;
      irqReq_r    <= irqReq_nxt;
      irqVector_r <= VEC_TABLE[arbBus.winIdx];                            // RL12
      irqHigh_r   <= arbBus.winHigh;
      irqSrc_r    <= arbBus.winIdx;
      eligDly_r   <= eligVec;
      highDly_r   <= highVec;
    end
  end

  assign sfrRdData = rdData_r;
  assign irqReq    = irqReq_r;
  assign irqVector = irqVector_r;
  assign irqHigh   = irqHigh_r;
  assign inService = {inSvcHigh_r, inSvcLow_r};

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  wire [NUM_SRC-1:0] sameLvl = irqHigh_r ? highDly_r : ~highDly_r;
  wire [NUM_SRC-1:0] aboveSrc = NUM_SRC'((NUM_SRC'(1) << irqSrc_r) - NUM_SRC'(1));

  sequence s_gateOff;
    !mainGate_r[GLOBAL_GATE];
  endsequence
  sequence s_noReqAfter;
    ##1 !irqReq_r;
  endsequence
  sequence s_ackHigh;
    irqAck && irqReq_r && irqHigh_r;
  endsequence
  sequence s_ackLow;
    irqAck && irqReq_r && !irqHigh_r;
  endsequence
  sequence s_idleElig;
    (|eligVec) && !inSvcHigh_r && !inSvcLow_r && !irqAck;
  endsequence

  a_reset_clears_regs: assert property (@(posedge ref_clk) disable iff (1'b0) // RL4 RL6 RL7
    !rst_b |=> (mainGate_r == RST_MAIN && level_r == RST_LEVEL && auxGate_r == RST_AUX))
    else $error("registers not cleared by reset");
  a_gate_blocks_req: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL2
    s_gateOff |-> s_noReqAfter)
    else $error("request raised with global gate off");
  a_req_needs_enable: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL13
    irqReq_r |-> eligDly_r[irqSrc_r])
    else $error("request from a source not pending and enabled");
  a_aux_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL9
    (auxGate_r & ~AUX_USED) == ZERO_BYTE)
    else $error("reserved aux bits are set");
  a_aux_byte_only: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL7
    !wrAux |=> $stable(auxGate_r))
    else $error("aux register changed without byte write");
  a_bit_write_main: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL4
    (bitMain && !wrMain) |=> mainGate_r[$past(bitAddr[2:0])] == $past(bitWrVal))
    else $error("bit write to main register lost");
  a_bit_write_level: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL6
    (bitLevel && !wrLevel) |=> level_r[$past(bitAddr[2:0])] == $past(bitWrVal))
    else $error("bit write to level register lost");
  a_vector_matches_src: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL12
    irqReq_r |-> irqVector_r == VEC_TABLE[irqSrc_r])
    else $error("vector does not match winning source");
  a_level_matches_src: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL5
    irqReq_r |-> irqHigh_r == highDly_r[irqSrc_r])
    else $error("request level differs from level bit");
  a_poll_order_kept: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL11
    irqReq_r |-> (eligDly_r & sameLvl & aboveSrc) == '0)
    else $error("higher polling source skipped");
  a_high_over_low: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL10
    (irqReq_r && !irqHigh_r) |-> (eligDly_r & highDly_r) == '0)
    else $error("low request chosen over pending high");
  a_no_same_preempt: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL10
    inSvcHigh_r |=> !irqReq_r ##0 (!inSvcLow_r || $past(irqDone) || irqReq_r == 1'b0))
    else $error("request while high level in service");
  a_low_only_high: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL10
    (inSvcLow_r && !inSvcHigh_r) |=> (!irqReq_r || irqHigh_r || $past(irqDone)))
    else $error("low request preempted low service");
  a_byte_write_main: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL4
    wrMain |=> mainGate_r == $past(sfrWrData))
    else $error("byte write to main register lost");
  a_byte_write_level: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL6
    wrLevel |=> level_r == $past(sfrWrData))
    else $error("byte write to level register lost");
  a_read_aux_value: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL7
    (sfrRdEn && sfrAddr == ADDR_AUX) |=> sfrRdData == $past(auxGate_r))
    else $error("aux read data differs from register");
  a_ack_sets_high: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL10
    s_ackHigh |=> inSvcHigh_r)
    else $error("accepted high request not marked in service");
  a_ack_sets_low: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL10
    s_ackLow |=> inSvcLow_r)
    else $error("accepted low request not marked in service");
  a_req_when_idle: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL13
    s_idleElig |=> irqReq_r)
    else $error("eligible request not raised");
endmodule : tlic_ctrl

// ### dv/tlic_core_model.sv
`timescale 1ns/1ps
module tlic_core_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       irqReq,
  input  wire logic [1:0] ackDelay,
  input  wire logic       retire,
  output logic            irqAck,
  output logic            irqDone
);
  logic [1:0] waitCnt_r;
  logic       waiting;
  // Accepts a standing offer only, after a chosen number of idle cycles
  assign waiting = irqReq && !irqAck && (waitCnt_r != ackDelay);
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      waitCnt_r <= 2'h0;
      irqAck    <= 1'b0;
      irqDone   <= 1'b0;
    end else begin
      irqDone   <= retire;
      irqAck    <= irqReq && !irqAck && (waitCnt_r == ackDelay);
      waitCnt_r <= waiting ? waitCnt_r + 2'h1 : 2'h0;
    end
  end
endmodule : tlic_core_model

// ### dv/two_level_interrupt_control_test.sv
`timescale 1ns/1ps
module two_level_interrupt_control_test;
  import tlic_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, bitAddr = 8'h00, sfrRdData, r;
  logic sfrWrEn = 1'b0, sfrRdEn = 1'b0, bitWrEn = 1'b0, bitWrVal = 1'b0;
  logic [NUM_SRC-1:0] pendIn = '0;
  logic irqAck, irqDone, irqReq, irqHigh, retire = 1'b0, rdV = 1'b0;
  logic [15:0] irqVector;
  logic [1:0] inService, ackDelay = 2'h0;
  int fails = 0, samplesChecked = 0, acks = 0, seed = 32'hb319_5790;
  string nmQ[$];
  logic [16:0] expQ[$];
  logic [15:0] vec [9] = '{16'h0043, 16'h0003, 16'h0033, 16'h000B, 16'h0013,
                           16'h001B, 16'h003B, 16'h0023, 16'h002B};
  logic [7:0] enM [9] = '{8'h00, 8'h01, 8'h40, 8'h02, 8'h04, 8'h08, 8'h00, 8'h10, 8'h20};
  logic [7:0] enA [9] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
  logic [7:0] lvM [9] = '{8'h00, 8'h01, 8'h40, 8'h02, 8'h04, 8'h08, 8'h80, 8'h10, 8'h20};

  always #4 ref_clk = ~ref_clk;

  tlic_ctrl u_tlic_ctrl (.ref_clk(ref_clk), .rst_b(rst_b), .sfrAddr(sfrAddr),
    .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
    .bitAddr(bitAddr), .bitWrEn(bitWrEn), .bitWrVal(bitWrVal), .pendIn(pendIn),
    .irqAck(irqAck), .irqDone(irqDone), .irqReq(irqReq), .irqVector(irqVector),
    .irqHigh(irqHigh), .inService(inService));
  tlic_core_model u_tlic_core_model (.ref_clk(ref_clk), .rst_b(rst_b), .irqReq(irqReq),
    .ackDelay(ackDelay), .retire(retire), .irqAck(irqAck), .irqDone(irqDone));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checked %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [16:0] seen, input logic [16:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick();
    @(negedge ref_clk);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick();
    sfrAddr   = a;
    sfrWrData = d;
    sfrWrEn   = 1'b1;
    tick();
    sfrWrEn   = 1'b0;
  endtask : wr
  task automatic bw(input logic [7:0] a, input logic v);
    tick();
    bitAddr  = a;
    bitWrVal = v;
    bitWrEn  = 1'b1;
    tick();
    bitWrEn  = 1'b0;
  endtask : bw
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    nmQ.push_back("read data");
    expQ.push_back({9'h000, e});
    tick();
    sfrAddr = a;
    sfrRdEn = 1'b1;
    tick();
    sfrRdEn = 1'b0;
    tick();
  endtask : rd
  task automatic offer(input logic [8:0] p, input logic [16:0] e);
    int n;
    n = acks;
    nmQ.push_back("offered vector");
    expQ.push_back(e);
    ackDelay = 2'($random(seed));
    tick();
    pendIn = p;
    for (int k = 0; k < 20 && acks == n; k++) tick();
    if (acks == n) begin
      fails++;
      $display("ERROR offered vector expected %h seen none", e);
      complete_run();
    end
    pendIn = '0;
  endtask : offer
  task automatic finish_isr();
    tick();
    retire = 1'b1;
    tick();
    retire = 1'b0;
    tick();
  endtask : finish_isr
  task automatic quiet(input string nm);
    repeat (4) begin
      tick();
      chk(nm, {16'h0000, irqReq}, 17'h0_0000);
    end
  endtask : quiet

  ////////////////////////////////////////////////////////////////////////////////
  // Watches read data and accepted offers, oldest note first
  always @(posedge ref_clk) begin
    rdV <= sfrRdEn;
    if (rdV) chk(nmQ.pop_front(), {9'h000, sfrRdData}, expQ.pop_front());
    if (irqAck && irqReq) begin
      chk(nmQ.pop_front(), {irqHigh, irqVector}, expQ.pop_front());
      acks++;
    end
  end

  initial begin
    repeat (4) tick();
    rst_b = 1'b1;
    rd(ADDR_MAIN, 8'h00);
    rd(ADDR_AUX, 8'h00);
    rd(ADDR_LEVEL, 8'h00);
    rd(8'hA0, 8'h00);
    r = 8'($random(seed));
    wr(ADDR_MAIN, r);
    rd(ADDR_MAIN, r);
    wr(ADDR_AUX, r);
    rd(ADDR_AUX, r & 8'h03);
    wr(ADDR_LEVEL, ~r);
    for (int i = 0; i < 8; i++) bw(8'hB8 + 8'(i), r[i]);
    rd(ADDR_LEVEL, r);
    wr(ADDR_MAIN, 8'h00);
    bw(8'hAF, 1'b1);
    bw(8'hA8, 1'b1);
    rd(ADDR_MAIN, 8'h81);
    $display("test registers done");
    wr(ADDR_LEVEL, 8'h00);
    wr(ADDR_AUX, 8'h03);
    wr(ADDR_MAIN, 8'h7F);
    pendIn = 9'h1FF;
    quiet("request with gate closed");
    pendIn = '0;
    $display("test gate done");
    for (int i = 0; i < 9; i++) begin
      wr(ADDR_MAIN, 8'h80 | enM[i]);
      wr(ADDR_AUX, enA[i]);
      offer(9'h1FF, {1'b0, vec[i]});
      finish_isr();
    end
    $display("test enables done");
    wr(ADDR_MAIN, 8'hFF);
    wr(ADDR_AUX, 8'hFF);
    for (int i = 0; i < 9; i++) begin
      offer(9'h1FF << i, {1'b0, vec[i]});
      finish_isr();
    end
    $display("test polling done");
    for (int i = 1; i < 9; i++) begin
      wr(ADDR_LEVEL, lvM[i]);
      offer(9'h1FF, {1'b1, vec[i]});
      chk("in service", {15'h0000, inService}, 17'h0_0002);
      finish_isr();
    end
    $display("test levels done");
    wr(ADDR_LEVEL, 8'h20);
    offer(9'h080, {1'b0, vec[7]});
    offer(9'h102, {1'b1, vec[8]});
    chk("nested service", {15'h0000, inService}, 17'h0_0003);
    pendIn = 9'h002;
    quiet("request during high service");
    finish_isr();
    quiet("same level request");
    finish_isr();
    offer(9'h002, {1'b0, vec[1]});
    finish_isr();
    $display("test preemption done");
    complete_run();
  end
endmodule : two_level_interrupt_control_test
